//--- hw/rpi_pkg.sv
// Register map and field layout of the receive-port event status block
package rpi_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_SELECT_ADDR       = 8'h4C;
  localparam logic [7:0] CAMERA_RX_STATUS_ADDR  = 8'h7A;
  localparam logic [7:0] EVENT_ENABLES_LOW_ADDR = 8'hD9;
  localparam logic [7:0] EVENT_FLAGS_HIGH_ADDR  = 8'hDA;
  localparam logic [7:0] EVENT_FLAGS_LOW_ADDR   = 8'hDB;
  localparam logic [7:0] FWD_GPIO_STATUS_ADDR   = 8'hDC;
  localparam logic [7:0] SENSOR_FALL_ADDR       = 8'hDF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ENABLES_LOW_RESET = 8'h00;
  localparam logic [4:0] FLAGS_HIGH_RESET  = 5'h00;
  localparam logic [6:0] FLAGS_LOW_RESET   = 7'h00;
  localparam logic [3:0] IO_RESET          = 4'h0;
  localparam logic [7:0] DATA_ZERO         = 8'h00;

  // ----------------------------------------------------------------
  // High event register fields
  // ----------------------------------------------------------------
  localparam int HI_FWD_GPIO = 4;
  localparam int HI_SENSOR   = 3;
  localparam int HI_ENC_ERR  = 2;
  localparam int HI_SEQ_ERR  = 1;
  localparam int HI_CRC_ERR  = 0;
  localparam int HI_WIDTH    = 5;

  // ----------------------------------------------------------------
  // Low event register fields
  // ----------------------------------------------------------------
  localparam int LO_LINE_LEN = 6;
  localparam int LO_LINE_CNT = 5;
  localparam int LO_OVERFLOW = 4;
  localparam int LO_CSI_ERR  = 3;
  localparam int LO_PARITY   = 2;
  localparam int LO_PORT_OK  = 1;
  localparam int LO_LOCK     = 0;
  localparam int LO_WIDTH    = 7;

  // ----------------------------------------------------------------
  // Forward GPIO status fields and edge enable layout
  // ----------------------------------------------------------------
  localparam int IO_COUNT     = 4;
  localparam int IO_EVENT_LSB = 4;
  localparam int EDGE_FALL    = 1;
  localparam int EDGE_RISE    = 0;

endpackage

//--- hw/rpi_port_events.sv
// Per-port event flags, forward GPIO status and interrupt output
module rpi_port_events #(
  parameter int         NPORTS           = 2,
  parameter logic [7:0] STATUS_FIRST_ADDR  = 8'h4D,
  parameter logic [7:0] STATUS_SECOND_ADDR = 8'h4E,
  parameter logic [7:0] SENSOR_RISE_ADDR   = 8'hDE
) (
  // Clock and reset
  input  wire  logic       mclk,
  input  wire  logic       rstn,
  // Register access from the serial slave
  input  wire  logic [7:0] reg_addr,
  input  wire  logic       reg_wr,
  input  wire  logic       reg_rd,
  input  wire  logic [7:0] reg_wdata,
  output logic       [7:0] reg_rdata,
  // Per-port event pulses
  input  wire  logic [NPORTS-1:0] link_encoding_fault,
  input  wire  logic [NPORTS-1:0] ctrl_sequence_fault,
  input  wire  logic [NPORTS-1:0] ctrl_crc_fault,
  input  wire  logic [NPORTS-1:0] line_length_changed,
  input  wire  logic [NPORTS-1:0] line_count_changed,
  input  wire  logic [NPORTS-1:0] rx_overflow,
  input  wire  logic [NPORTS-1:0] csi_rx_fault,
  input  wire  logic [NPORTS-1:0] parity_fault,
  input  wire  logic [NPORTS-1:0] port_valid_changed,
  input  wire  logic [NPORTS-1:0] lock_changed,
  input  wire  logic [NPORTS-1:0] sensor_changed,
  // Forward GPIO levels and edge enables
  input  wire  logic [3:0] fwd_io_level [NPORTS],
  input  wire  logic [7:0] fwd_edge_en  [NPORTS],
  // High event enables from the neighbouring register
  input  wire  logic [4:0] high_enables [NPORTS],
  // Interrupt
  output logic             irq
);

  localparam int PSW = (NPORTS > 1) ? $clog2(NPORTS) : 1;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [PSW-1:0] port_sel,        next_port_sel;
  logic [7:0]     enables_low    [NPORTS];
  logic [7:0]     next_enables_low [NPORTS];
  logic [4:0]     flags_high     [NPORTS];
  logic [4:0]     next_flags_high [NPORTS];
  logic [6:0]     flags_low      [NPORTS];
  logic [6:0]     next_flags_low [NPORTS];
  logic [3:0]     io_events      [NPORTS];
  logic [3:0]     next_io_events [NPORTS];
  logic [3:0]     io_prev        [NPORTS];
  logic [3:0]     next_io_prev   [NPORTS];
  logic [NPORTS-1:0] rise_seen,    next_rise_seen;
  logic [NPORTS-1:0] fall_seen,    next_fall_seen;
  logic [7:0]     next_rdata;
  logic           next_irq;
  logic           irq_cause;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic       sel;
    logic       rd_first;
    logic       rd_second;
    logic       rd_csi;
    logic       rd_gpio;
    logic       rd_rise;
    logic       rd_fall;
    logic       sens_done;
    logic [3:0] edges;
    logic [4:0] hi_set;
    logic [4:0] hi_clr;
    logic [6:0] lo_set;
    logic [6:0] lo_clr;
    sel = 1'b0;
    rd_first = 1'b0;
    rd_second = 1'b0;
    rd_csi = 1'b0;
    rd_gpio = 1'b0;
    rd_rise = 1'b0;
    rd_fall = 1'b0;
    sens_done = 1'b0;
    edges = IO_ZERO();
    hi_set = rpi_pkg::FLAGS_HIGH_RESET;
    hi_clr = rpi_pkg::FLAGS_HIGH_RESET;
    lo_set = rpi_pkg::FLAGS_LOW_RESET;
    lo_clr = rpi_pkg::FLAGS_LOW_RESET;
    irq_cause = 1'b0;
    next_port_sel = port_sel;
    next_rise_seen = rise_seen;
    next_fall_seen = fall_seen;
    next_rdata = rpi_pkg::DATA_ZERO;
    if (reg_wr && reg_addr == rpi_pkg::PORT_SELECT_ADDR) begin
      next_port_sel = reg_wdata[PSW-1:0];
    end
    if (reg_rd && reg_addr == rpi_pkg::PORT_SELECT_ADDR) begin
      next_rdata[PSW-1:0] = port_sel;
    end
    for (int p = 0; p < NPORTS; p++) begin
      sel = (port_sel == PSW'(p));
      rd_first = reg_rd && sel && reg_addr == STATUS_FIRST_ADDR;
      rd_second = reg_rd && sel && reg_addr == STATUS_SECOND_ADDR;
      rd_csi = reg_rd && sel && reg_addr == rpi_pkg::CAMERA_RX_STATUS_ADDR;
      rd_gpio = reg_rd && sel && reg_addr == rpi_pkg::FWD_GPIO_STATUS_ADDR;
      rd_rise = reg_rd && sel && reg_addr == SENSOR_RISE_ADDR;
      rd_fall = reg_rd && sel && reg_addr == rpi_pkg::SENSOR_FALL_ADDR;
      // Edge detection on the forward GPIO levels
      for (int i = 0; i < rpi_pkg::IO_COUNT; i++) begin
        edges[i] = (fwd_io_level[p][i] && !io_prev[p][i] &&
                    fwd_edge_en[p][2*i+rpi_pkg::EDGE_RISE]) ||
                   (!fwd_io_level[p][i] && io_prev[p][i] &&
                    fwd_edge_en[p][2*i+rpi_pkg::EDGE_FALL]);
      end
      next_io_prev[p] = fwd_io_level[p];
      // Sensor flag waits for both rise and fall status reads
      sens_done = (rise_seen[p] || rd_rise) && (fall_seen[p] || rd_fall);
      next_rise_seen[p] = sens_done ? 1'b0 : (rise_seen[p] || rd_rise);
      next_fall_seen[p] = sens_done ? 1'b0 : (fall_seen[p] || rd_fall);
      hi_set = rpi_pkg::FLAGS_HIGH_RESET;
      hi_set[rpi_pkg::HI_FWD_GPIO] = |edges;
      hi_set[rpi_pkg::HI_SENSOR]   = sensor_changed[p];
      hi_set[rpi_pkg::HI_ENC_ERR]  = link_encoding_fault[p];
      hi_set[rpi_pkg::HI_SEQ_ERR]  = ctrl_sequence_fault[p];
      hi_set[rpi_pkg::HI_CRC_ERR]  = ctrl_crc_fault[p];
      hi_clr = rpi_pkg::FLAGS_HIGH_RESET;
      hi_clr[rpi_pkg::HI_FWD_GPIO] = rd_gpio;
      hi_clr[rpi_pkg::HI_SENSOR]   = sens_done;
      hi_clr[rpi_pkg::HI_ENC_ERR]  = rd_second;
      hi_clr[rpi_pkg::HI_SEQ_ERR]  = rd_first;
      hi_clr[rpi_pkg::HI_CRC_ERR]  = rd_first;
      lo_set = rpi_pkg::FLAGS_LOW_RESET;
      lo_set[rpi_pkg::LO_LINE_LEN] = line_length_changed[p];
      lo_set[rpi_pkg::LO_LINE_CNT] = line_count_changed[p];
      lo_set[rpi_pkg::LO_OVERFLOW] = rx_overflow[p];
      lo_set[rpi_pkg::LO_CSI_ERR]  = csi_rx_fault[p];
      lo_set[rpi_pkg::LO_PARITY]   = parity_fault[p];
      lo_set[rpi_pkg::LO_PORT_OK]  = port_valid_changed[p];
      lo_set[rpi_pkg::LO_LOCK]     = lock_changed[p];
      lo_clr = rpi_pkg::FLAGS_LOW_RESET;
      lo_clr[rpi_pkg::LO_LINE_LEN] = rd_second;
      lo_clr[rpi_pkg::LO_LINE_CNT] = rd_second;
      lo_clr[rpi_pkg::LO_OVERFLOW] = rd_second;
      lo_clr[rpi_pkg::LO_CSI_ERR]  = rd_csi;
      lo_clr[rpi_pkg::LO_PARITY]   = rd_first;
      lo_clr[rpi_pkg::LO_PORT_OK]  = rd_first;
      lo_clr[rpi_pkg::LO_LOCK]     = rd_first;
      // Set wins over a clear in the same cycle
      next_flags_high[p] = (flags_high[p] & ~hi_clr) | hi_set;
      next_flags_low[p]  = (flags_low[p] & ~lo_clr) | lo_set;
      next_io_events[p]  = (rd_gpio ? IO_ZERO() : io_events[p]) |
                           edges;
      next_enables_low[p] = enables_low[p];
      if (reg_wr && sel && reg_addr == rpi_pkg::EVENT_ENABLES_LOW_ADDR) begin
        next_enables_low[p] = reg_wdata;
      end
      // Read data of the selected port, reserved bits at zero
      if (reg_rd && sel) begin
        case (reg_addr)
          rpi_pkg::EVENT_ENABLES_LOW_ADDR: next_rdata = enables_low[p];
          rpi_pkg::EVENT_FLAGS_HIGH_ADDR:
            next_rdata = {3'h0, flags_high[p]};
          rpi_pkg::EVENT_FLAGS_LOW_ADDR:
            next_rdata = {1'h0, flags_low[p]};
          rpi_pkg::FWD_GPIO_STATUS_ADDR:
            next_rdata = {io_events[p], fwd_io_level[p]};
          default: ;
        endcase
      end
      irq_cause = irq_cause ||
                  |(flags_low[p] & enables_low[p][6:0]) ||
                  |(flags_high[p] & high_enables[p]);
    end
    next_irq = irq_cause;
  end

  function automatic logic [3:0] IO_ZERO();
    return rpi_pkg::IO_RESET;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      port_sel <= '0;
      rise_seen <= '0;
      fall_seen <= '0;
      reg_rdata <= rpi_pkg::DATA_ZERO;
      irq <= 1'b0;
      for (int p = 0; p < NPORTS; p++) begin
        enables_low[p] <= rpi_pkg::ENABLES_LOW_RESET;
        flags_high[p]  <= rpi_pkg::FLAGS_HIGH_RESET;
        flags_low[p]   <= rpi_pkg::FLAGS_LOW_RESET;
        io_events[p]   <= rpi_pkg::IO_RESET;
        io_prev[p]     <= rpi_pkg::IO_RESET;
      end
    end else begin
      port_sel <= next_port_sel;
      rise_seen <= next_rise_seen;
      fall_seen <= next_fall_seen;
      reg_rdata <= next_rdata;
      irq <= next_irq;
      for (int p = 0; p < NPORTS; p++) begin
        enables_low[p] <= next_enables_low[p];
        flags_high[p]  <= next_flags_high[p];
        flags_low[p]   <= next_flags_low[p];
        io_events[p]   <= next_io_events[p];
        io_prev[p]     <= next_io_prev[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_read_first0;
    reg_rd && reg_addr == STATUS_FIRST_ADDR && port_sel == '0;
  endsequence

  sequence s_read_second1;
    reg_rd && reg_addr == STATUS_SECOND_ADDR && port_sel != '0;
  endsequence

  a_lock_sets: assert property (lock_changed[0] |=> flags_low[0][0])
    else $error("lock change did not set its flag");

  sequence s_read_gpio0;
    reg_rd && reg_addr == rpi_pkg::FWD_GPIO_STATUS_ADDR && port_sel == '0;
  endsequence

  a_first_clears: assert property (
      s_read_first0 ##0 !lock_changed[0] ##0 !ctrl_crc_fault[0]
      ##0 !ctrl_sequence_fault[0] |=> !flags_low[0][0] &&
      flags_high[0][1:0] == 2'h0)
    else $error("first status read did not clear flags");

  a_set_wins: assert property (s_read_first0 ##0 ctrl_crc_fault[0]
      |=> flags_high[0][0])
    else $error("event lost in clearing cycle");

  a_lock_set_wins: assert property (s_read_first0 ##0 lock_changed[0]
      |=> flags_low[0][0])
    else $error("lock event lost in clearing cycle");

  a_other_port_kept: assert property (
      flags_low[0][6] ##0 s_read_second1 |=> flags_low[0][6])
    else $error("read of another port cleared port 0");

  a_port_select: assert property (
      reg_wr && reg_addr == rpi_pkg::PORT_SELECT_ADDR |=>
      port_sel == $past(reg_wdata[PSW-1:0]))
    else $error("port select write not taken");

  a_reserved_zero: assert property (
      reg_rd && reg_addr == rpi_pkg::EVENT_FLAGS_HIGH_ADDR |=>
      reg_rdata[7:5] == 3'h0)
    else $error("reserved high bits not zero");

  a_reserved_low: assert property (
      reg_rd && reg_addr == rpi_pkg::EVENT_FLAGS_LOW_ADDR |=> !reg_rdata[7])
    else $error("reserved low bit not zero");

  a_enabled_irq: assert property (
      flags_low[0][0] && enables_low[0][0] |=> irq)
    else $error("enabled flag gave no interrupt");

  a_quiet_irq: assert property (!irq_cause [*2] |-> !irq)
    else $error("interrupt without enabled flag");

  a_gpio_rise: assert property (
      fwd_io_level[0][0] && !io_prev[0][0] && fwd_edge_en[0][0] |=>
      io_events[0][0] && flags_high[0][4])
    else $error("enabled rising edge not flagged");

  a_gpio_fall: assert property (
      !fwd_io_level[0][0] && io_prev[0][0] && fwd_edge_en[0][1] |=>
      io_events[0][0] && flags_high[0][4])
    else $error("enabled falling edge not flagged");

  a_gpio_read_clr: assert property (
      s_read_gpio0 ##0 (io_events[0][0] && fwd_io_level[0] == io_prev[0])
      |=> !io_events[0][0] && reg_rdata[4])
    else $error("gpio event not cleared on read");

  a_gpio_level: assert property (
      s_read_gpio0 |=> reg_rdata[3:0] == $past(fwd_io_level[0]))
    else $error("gpio level not reported");

  a_sensor_both: assert property (
      flags_high[0][3] && !sensor_changed[0] && !rise_seen[0] &&
      !fall_seen[0] && port_sel == '0 && reg_rd &&
      reg_addr == SENSOR_RISE_ADDR |=> flags_high[0][3])
    else $error("sensor flag cleared by single read");

endmodule

//--- tb/rpi_host.sv
// Register host model driving the block's strobe access port
module rpi_host (
  // Clock
  input  wire logic       mclk,
  // Register access
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // ----------------------------------------------------------------
  // Accesses: held until the sampling edge, then address inverted
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
endmodule

//--- tb/rx_port_interrupt_status_bench.sv
// Self-checking bench for the receive-port event status block
module rx_port_interrupt_status_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic       reg_wr, reg_rd, irq;
  logic [1:0] ev [11];
  logic [3:0] io_lvl [2];
  logic [7:0] edge_en [2];
  logic [4:0] hi_en [2];
  int         num_errors = 0;
  int         samples_checked = 0;
  // Event index: enc, seq, crc, len, cnt, ovf, csi, par, valid, lock, sensor
  localparam logic [7:0] FREG [11] = '{8'hDA, 8'hDA, 8'hDA, 8'hDB, 8'hDB,
    8'hDB, 8'hDB, 8'hDB, 8'hDB, 8'hDB, 8'hDA};
  localparam int FBIT [11] = '{2, 1, 0, 6, 5, 4, 3, 2, 1, 0, 3};
  localparam logic [7:0] CLR [11] = '{8'h4E, 8'h4D, 8'h4D, 8'h4E, 8'h4E,
    8'h4E, 8'h7A, 8'h4D, 8'h4D, 8'h4D, 8'hDF};
  localparam logic [7:0] OTH [11] = '{8'h4D, 8'h4E, 8'h4E, 8'h4D, 8'h4D,
    8'h4D, 8'h4D, 8'h4E, 8'h4E, 8'h4E, 8'hDE};

  always #25 mclk = ~mclk;

  rpi_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  rpi_port_events uut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .link_encoding_fault(ev[0]),
    .ctrl_sequence_fault(ev[1]), .ctrl_crc_fault(ev[2]),
    .line_length_changed(ev[3]), .line_count_changed(ev[4]),
    .rx_overflow(ev[5]), .csi_rx_fault(ev[6]), .parity_fault(ev[7]),
    .port_valid_changed(ev[8]), .lock_changed(ev[9]),
    .sensor_changed(ev[10]), .fwd_io_level(io_lvl), .fwd_edge_en(edge_en),
    .high_enables(hi_en), .irq(irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic pulse(input logic [10:0] m, input int p);
    @(posedge mclk);
    #1;
    for (int k = 0; k < 11; k++) ev[k][p] = m[k];
    @(posedge mclk);
    #1;
    for (int k = 0; k < 11; k++) ev[k][p] = 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic close_out;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    idle(2000);
    num_errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    for (int k = 0; k < 11; k++) ev[k] = 2'b00;
    for (int p = 0; p < 2; p++) begin
      io_lvl[p] = 4'h0;
      edge_en[p] = 8'h00;
      hi_en[p] = 5'h00;
    end
    idle(8);
    rstn = 1'b1;
    for (int a = 8'hD9; a <= 8'hDC; a++) begin
      host.rd(a[7:0], d);
      chk("reset value", d, 8'h00);
    end
    for (int k = 0; k < 11; k++) begin
      pulse(11'h001 << k, 0);
      host.rd(FREG[k], d);
      chk("flag set", d, 8'h01 << FBIT[k]);
      chk("irq masked", {7'h00, irq}, 8'h00);
      host.rd(OTH[k], d);
      host.rd(FREG[k], d);
      chk("flag kept", d, 8'h01 << FBIT[k]);
      host.rd(CLR[k], d);
      host.rd(FREG[k], d);
      chk("flag clear", d, 8'h00);
    end
    pulse(11'h7FF, 0);
    host.wr(8'hDA, 8'hFF);
    host.wr(8'hDB, 8'hFF);
    host.rd(8'hDA, d);
    chk("high reserved", d, 8'h0F);
    host.rd(8'hDB, d);
    chk("low reserved", d, 8'h7F);
    foreach (CLR[k]) host.rd(CLR[k], d);
    host.rd(8'hDE, d);
    host.rd(8'hDA, d);
    chk("high cleared", d, 8'h00);
    host.wr(8'h4C, 8'h01);
    host.rd(8'h4C, d);
    chk("port select", d, 8'h01);
    pulse(11'h208, 0);
    host.rd(8'hDB, d);
    chk("other port", d, 8'h00);
    host.rd(8'h4E, d);
    pulse(11'h200, 1);
    host.rd(8'hDB, d);
    chk("port one flag", d, 8'h01);
    host.rd(8'h4D, d);
    host.rd(8'hDB, d);
    chk("port one clear", d, 8'h00);
    host.wr(8'h4C, 8'h00);
    host.rd(8'hDB, d);
    chk("own port", d, 8'h41);
    host.rd(8'h4E, d);
    host.wr(8'hD9, 8'h01);
    idle(2);
    chk("irq on", {7'h00, irq}, 8'h01);
    fork
      host.rd(8'h4D, d);
      pulse(11'h204, 0);
    join
    host.rd(8'hDB, d);
    chk("event at clear", d, 8'h01);
    host.rd(8'hDA, d);
    chk("crc at clear", d, 8'h01);
    host.rd(8'h4D, d);
    idle(2);
    chk("irq off", {7'h00, irq}, 8'h00);
    edge_en[0] = 8'h01;
    hi_en[0] = 5'h10;
    io_lvl[0] = 4'h1;
    idle(3);
    chk("irq gpio", {7'h00, irq}, 8'h01);
    host.rd(8'hDA, d);
    chk("gpio high flag", d, 8'h10);
    host.rd(8'hDC, d);
    chk("gpio status", d, 8'h11);
    host.rd(8'hDC, d);
    chk("gpio read clear", d, 8'h01);
    host.rd(8'hDA, d);
    chk("gpio flag clear", d, 8'h00);
    io_lvl[0] = 4'h0;
    idle(3);
    host.wr(8'hDC, 8'hFF);
    host.rd(8'hDC, d);
    chk("fall masked", d, 8'h00);
    edge_en[0] = 8'h02;
    io_lvl[0] = 4'h1;
    idle(2);
    io_lvl[0] = 4'h0;
    idle(2);
    host.rd(8'hDA, d);
    chk("fall high flag", d, 8'h10);
    host.rd(8'hDC, d);
    chk("fall event", d, 8'h10);
    close_out();
  end
endmodule
